// [logic/dit_defs.vh]
// Constants for the digital input terminal function block.
// Assumes a 40 MHz system clock and six input terminals.
`ifndef DIT_DEFS_VH
`define DIT_DEFS_VH
`define DIT_NTERM        6
`define DIT_CODE_W       7
`define DIT_FREQ_W       16
// Terminal function codes
`define DIT_F_JOG        7'h09
`define DIT_F_UP         7'h0A
`define DIT_F_DOWN       7'h0B
`define DIT_F_UP2        7'h0C
`define DIT_F_DOWN2      7'h0D
`define DIT_F_FORWARD_JOG       7'h0E
`define DIT_F_REVERSE_JOG       7'h0F
`define DIT_F_ACC1       7'h10
`define DIT_F_ACC2       7'h11
`define DIT_F_HOLD       7'h12
`define DIT_F_BB_NO      7'h13
`define DIT_F_BB_NC      7'h14
`define DIT_F_FST_NO     7'h15
`define DIT_F_FST_NC     7'h16
`define DIT_F_EF_LO      7'h17
`define DIT_F_EF_HI      7'h26
`define DIT_F_FRST       7'h27
`define DIT_F_OH2        7'h28
// Frequency source code for terminal up/down
`define DIT_SRC_UPDOWN   3'h2
// Analog input setting that makes it a lower-limit source
`define DIT_AIN_LOWER    2'h2
// External fault responses
`define DIT_EF_RAMP      2'h0
`define DIT_EF_COAST     2'h1
`define DIT_EF_FAST      2'h2
`define DIT_EF_ALARM     2'h3
// Timing
`define DIT_CLK_KHZ      40000
`define DIT_DEB_MS       2
`define DIT_DEB_CYC      (`DIT_DEB_MS * `DIT_CLK_KHZ)
`define DIT_JOGCF_MS     500
`define DIT_JOGCF_CYC    (`DIT_JOGCF_MS * `DIT_CLK_KHZ)
`define DIT_UDSTEP_MS    10
`define DIT_UDSTEP_CYC   (`DIT_UDSTEP_MS * `DIT_CLK_KHZ)
`define DIT_BLINK_BIT    23
`endif

// [logic/dit_top.v]
// Digital input terminal function logic of a motor drive.
// Assumes control inputs and parameters synchronous or static;
// ramp, speed search and motor control sit outside.
`timescale 1ns/10ps
`include "dit_defs.vh"

module dit_top #(
   parameter DEB_CYC    = `DIT_DEB_CYC,
   parameter JOGCF_CYC  = `DIT_JOGCF_CYC,
   parameter UDSTEP_CYC = `DIT_UDSTEP_CYC
) (
   input  wire        clk_sys,
   input  wire        rstn,
   input  wire [5:0]  term_in,
   input  wire [41:0] input_function_select,
   input  wire        run_cmd,
   input  wire        drive_running,
   input  wire        motor_stopped,
   input  wire [15:0] freq_ref_in,
   input  wire [15:0] jog_frequency_param,
   input  wire [15:0] freq_upper_limit,
   input  wire [15:0] freq_lower_limit,
   input  wire [15:0] analog_in,
   input  wire [1:0]  analog_function,
   input  wire [2:0]  freq_source_select_1,
   input  wire [2:0]  freq_source_select_2,
   input  wire        source_2_active,
   input  wire        freq_command_hold_enable,
   input  wire        reverse_disable,
   output reg  [15:0] freq_command,
   output reg         run_reverse,
   output reg         jog_run,
   output reg         jog_ramp_sel,
   output reg  [1:0]  ramp_pair_sel,
   output reg         ramp_hold,
   output reg         output_disable,
   output wire        output_block_alarm,
   output reg         speed_search_start,
   output reg         fast_stop_active,
   output reg         ramp_stop_req,
   output reg         jog_conflict_alarm,
   output reg         input_selection_error,
   output reg         external_fault_indication,
   output reg  [2:0]  ext_fault_terminal,
   output reg  [1:0]  ext_fault_stop_mode,
   output reg         ext_fault_alarm,
   output reg         external_overheat_alarm
);

   // Per-terminal decoded function hits
   wire [5:0] t_jog, t_up, t_dn, t_up2, t_dn2;
   wire [5:0] t_forward_jog, t_reverse_jog, t_acc1, t_acc2, t_hold;
   wire [5:0] t_bb, t_fst, t_frst, t_oh;
   wire [5:0] a_up, a_dn;        // Assignment present
   wire [5:0] t_efdet;           // External fault detected
   wire [5:0] t_efalm;           // Alarm-only fault detected
   wire [5:0] t_eflatch;         // Latching fault detected
   wire [11:0] t_efresp;         // Response code per terminal
   wire [5:0] lvl;               // Debounced terminal levels

   genvar g;
   generate
      for (g = 0; g < `DIT_NTERM; g = g + 1) begin : term
         reg        s1;          // First sync stage
         reg        s2;          // Second sync stage
         reg        deb;         // Debounced level
         reg [16:0] cnt;         // Stability counter
         wire [6:0] code;
         wire [6:0] efi;
         wire       is_ef;
         wire       act;
         assign code = input_function_select[7*g +: 7];

         // Two-stage sync, then level must hold DEB_CYC
         always @(posedge clk_sys) begin
            if (!rstn) begin
               s1  <= 1'b0;
               s2  <= 1'b0;
               deb <= 1'b0;
               cnt <= 17'h00000;
            end else begin
               s1 <= term_in[g];
               s2 <= s1;
               if (s2 == deb) begin
                  cnt <= 17'h00000;
               end else if (cnt >= DEB_CYC - 1) begin
                  deb <= s2;
                  cnt <= 17'h00000;
               end else begin
                  cnt <= cnt + 17'h00001;
               end
            end
         end
         assign lvl[g] = deb;

         assign t_jog[g]  = deb & (code == `DIT_F_JOG);
         assign a_up[g]   = (code == `DIT_F_UP);
         assign a_dn[g]   = (code == `DIT_F_DOWN);
         assign t_up[g]   = deb & a_up[g];
         assign t_dn[g]   = deb & a_dn[g];
         assign t_up2[g]  = deb & (code == `DIT_F_UP2);
         assign t_dn2[g]  = deb & (code == `DIT_F_DOWN2);
         assign t_forward_jog[g] = deb & (code == `DIT_F_FORWARD_JOG);
         assign t_reverse_jog[g] = deb & (code == `DIT_F_REVERSE_JOG);
         assign t_acc1[g] = deb & (code == `DIT_F_ACC1);
         assign t_acc2[g] = deb & (code == `DIT_F_ACC2);
         assign t_hold[g] = deb & (code == `DIT_F_HOLD);
         // Normally-closed variants act on an open contact
         assign t_bb[g]   = (deb & (code == `DIT_F_BB_NO))
                          | (!deb & (code == `DIT_F_BB_NC));
         assign t_fst[g]  = (deb & (code == `DIT_F_FST_NO))
                          | (!deb & (code == `DIT_F_FST_NC));
         assign t_frst[g] = deb & (code == `DIT_F_FRST);
         assign t_oh[g]   = deb & (code == `DIT_F_OH2);

         // Fault code offset: bit0 polarity, bit1 run-only
         assign is_ef = (code >= `DIT_F_EF_LO)
                      && (code <= `DIT_F_EF_HI);
         assign efi   = code - `DIT_F_EF_LO;
         assign act   = efi[0] ? !deb : deb;
         assign t_efdet[g] = is_ef & act
                           & (!efi[1] | drive_running);
         assign t_efresp[2*g +: 2] = efi[3:2];
         assign t_efalm[g] = t_efdet[g]
                           & (efi[3:2] == `DIT_EF_ALARM);
         assign t_eflatch[g] = t_efdet[g]
                             & (efi[3:2] != `DIT_EF_ALARM);
      end
   endgenerate

   // Merged function levels
   wire jog  = |t_jog;
   wire up   = |t_up;
   wire dn   = |t_dn;
   wire up2  = |t_up2;
   wire dn2  = |t_dn2;
   wire forward_jog = |t_forward_jog;
   wire reverse_jog = |t_reverse_jog & !reverse_disable;
   wire blk  = |t_bb;
   wire fst  = |t_fst;
   wire frst = |t_frst;

   // Active frequency source selection
   wire [2:0] src_sel = source_2_active ? freq_source_select_2
                                        : freq_source_select_1;
   wire ud_en = (src_sel == `DIT_SRC_UPDOWN);

   // Lower limit may come from the analog input
   wire [15:0] low_lim =
      ((analog_function == `DIT_AIN_LOWER)
       && (analog_in < freq_lower_limit))
      ? analog_in : freq_lower_limit;

   // Up/down step prescaler; one unit per step period
   reg [18:0] ud_pre;
   wire       ud_tick = (ud_pre >= UDSTEP_CYC - 1);
   always @(posedge clk_sys) begin
      if (!rstn || ud_tick) begin
         ud_pre <= 19'h00000;
      end else begin
         ud_pre <= ud_pre + 19'h00001;
      end
   end

   // Up/down frequency command store
   reg  [15:0] ud_freq;
   reg  [15:0] next_ud;
   reg         run_q;        // Run command last cycle
   always @* begin
      next_ud = ud_freq;
      if (!run_cmd && !freq_command_hold_enable) begin
         next_ud = 16'h0000;
      end else if (!run_cmd && (up || dn)) begin
         next_ud = 16'h0000;
      end else if (run_cmd && ud_en && ud_tick) begin
         // Only one closed moves; both or none hold
         if (up && !dn && ud_freq < freq_upper_limit) begin
            next_ud = ud_freq + 16'h0001;
         end else if (dn && !up && ud_freq > low_lim) begin
            next_ud = ud_freq - 16'h0001;
         end
      end
      // Keep the stored value inside the limits while running
      if (run_cmd && next_ud > freq_upper_limit) begin
         next_ud = freq_upper_limit;
      end else if (run_cmd && next_ud < low_lim) begin
         next_ud = low_lim;
      end
   end
   always @(posedge clk_sys) begin
      if (!rstn) begin
         ud_freq <= 16'h0000;
         run_q   <= 1'b0;
      end else begin
         ud_freq <= next_ud;
         run_q   <= run_cmd;
      end
   end

   // Bias from second up/down pair, never the command itself
   reg [15:0] bias;
   always @(posedge clk_sys) begin
      if (!rstn) begin
         bias <= 16'h0000;
      end else if (ud_tick && up2 && !dn2
                   && bias < freq_upper_limit) begin
         bias <= bias + 16'h0001;
      end else if (ud_tick && dn2 && !up2
                   && bias != 16'h0000) begin
         bias <= bias - 16'h0001;
      end
   end

   // Base command before bias
   wire [15:0] base_f = ud_en ? ud_freq : freq_ref_in;
   // Sum kept one bit wider so an overflow can be clamped
   wire [16:0] biased = {1'b0, base_f} + {1'b0, bias};
   wire [15:0] biased_c =
      (biased > {1'b0, freq_upper_limit})
      ? freq_upper_limit : biased[15:0];
   wire jog_any = forward_jog | reverse_jog;

   // Frequency command, direction and ramp selection
   always @(posedge clk_sys) begin
      if (!rstn) begin
         freq_command  <= 16'h0000;
         run_reverse   <= 1'b0;
         jog_run       <= 1'b0;
         jog_ramp_sel  <= 1'b0;
         ramp_pair_sel <= 2'h0;
         ramp_hold     <= 1'b0;
      end else begin
         if (jog_any) begin
            // Forward wins if both; conflict timer handles that
            freq_command <= jog_frequency_param;
            run_reverse  <= !forward_jog;
            jog_run      <= 1'b1;
         end else if (jog) begin
            freq_command <= jog_frequency_param;
            jog_run      <= 1'b0;
         end else begin
            freq_command <= biased_c;
            jog_run      <= 1'b0;
         end
         // Direction only means something during a jog run
         if (!jog_any) begin
            run_reverse  <= 1'b0;
         end
         jog_ramp_sel  <= jog_any | jog;
         ramp_pair_sel <= {|t_acc2, |t_acc1};
         ramp_hold     <= |t_hold;
      end
   end

   // Both jog inputs held together: time then alarm
   reg [24:0] jcf_cnt;
   always @(posedge clk_sys) begin
      if (!rstn) begin
         jcf_cnt            <= 25'h0000000;
         jog_conflict_alarm <= 1'b0;
      end else if (forward_jog && (|t_reverse_jog)) begin
         if (jcf_cnt >= JOGCF_CYC - 1) begin
            jog_conflict_alarm <= 1'b1;
         end else begin
            jcf_cnt <= jcf_cnt + 25'h0000001;
         end
      end else begin
         jcf_cnt            <= 25'h0000000;
         jog_conflict_alarm <= 1'b0;
      end
   end

   // Output blocking, restart by speed search on release
   reg        blk_q;
   reg [23:0] blink;    // Free-running flash divider
   always @(posedge clk_sys) begin
      if (!rstn) begin
         output_disable     <= 1'b0;
         blk_q              <= 1'b0;
         speed_search_start <= 1'b0;
         blink              <= 24'h000000;
      end else begin
         blink              <= blink + 24'h000001;
         blk_q              <= blk;
         output_disable     <= blk;
         speed_search_start <= blk_q && !blk && run_cmd;
      end
   end
   // Flashes only while blocked
   assign output_block_alarm = output_disable
                             & blink[`DIT_BLINK_BIT];

   // Fast stop latch; restart blocked until all released
   always @(posedge clk_sys) begin
      if (!rstn) begin
         fast_stop_active <= 1'b0;
      end else if (fst && drive_running) begin
         fast_stop_active <= 1'b1;
      end else if (motor_stopped && !fst && !run_cmd) begin
         fast_stop_active <= 1'b0;
      end
   end

   // Lowest-numbered terminal with a latching fault
   reg [2:0] ef_num;
   reg [1:0] ef_resp;
   integer   k;
   always @* begin
      ef_num  = 3'h0;
      ef_resp = 2'h0;
      for (k = `DIT_NTERM - 1; k >= 0; k = k - 1) begin
         if (t_eflatch[k]) begin
            ef_num  = k[2:0] + 3'h1;
            ef_resp = t_efresp[2*k +: 2];
         end
      end
   end

   // Fault reset acts on closure only
   reg  frst_q;
   wire frst_edge = frst && !frst_q;

   // Latched external fault; a live fault wins over reset
   always @(posedge clk_sys) begin
      if (!rstn) begin
         external_fault_indication <= 1'b0;
         ext_fault_terminal        <= 3'h0;
         ext_fault_stop_mode       <= 2'h0;
         frst_q                    <= 1'b0;
      end else begin
         frst_q <= frst;
         if (|t_eflatch && !external_fault_indication) begin
            external_fault_indication <= 1'b1;
            ext_fault_terminal        <= ef_num;
            ext_fault_stop_mode       <= ef_resp;
         end else if (frst_edge && !drive_running
                      && !(|t_eflatch)) begin
            external_fault_indication <= 1'b0;
            ext_fault_terminal        <= 3'h0;
            ext_fault_stop_mode       <= 2'h0;
         end
      end
   end

   // Status levels: alarms, ramp stop, configuration check
   always @(posedge clk_sys) begin
      if (!rstn) begin
         ramp_stop_req           <= 1'b0;
         ext_fault_alarm         <= 1'b0;
         input_selection_error   <= 1'b0;
         external_overheat_alarm <= 1'b0;
      end else begin
         ramp_stop_req <= jog_conflict_alarm;
         ext_fault_alarm <= |t_efalm;
         input_selection_error <= (|a_up) ^ (|a_dn);
         external_overheat_alarm <= |t_oh;
      end
   end

endmodule

// [tb/dit_sva.sv]
// Checker for the input terminal function block, bound to dit_top.
// Assumes the small timing parameters handed on by the bind.
`timescale 1ns/10ps

module dit_sva #(
   parameter DEB_CYC    = 4,
   parameter JOGCF_CYC  = 50,
   parameter UDSTEP_CYC = 8
) (
   input wire        clk_sys,
   input wire        rstn,
   input wire        motor_stopped,
   input wire        reverse_disable,
   input wire        drive_running,
   input wire [15:0] jog_frequency_param,
   input wire [15:0] freq_command,
   input wire        run_reverse,
   input wire        jog_run,
   input wire        jog_ramp_sel,
   input wire        output_disable,
   input wire        output_block_alarm,
   input wire        speed_search_start,
   input wire        fast_stop_active,
   input wire        ramp_stop_req,
   input wire        jog_conflict_alarm,
   input wire        external_fault_indication,
   input wire [2:0]  ext_fault_terminal
);
   // All checks on the one system clock, quiet in reset
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_blk_alarm; output_block_alarm |-> output_disable; endproperty
   a_blk_alarm: assert property (p_blk_alarm)
      else $error("block alarm without blocked output");
   property p_search;
      speed_search_start |-> !output_disable ##1 !speed_search_start;
   endproperty
   a_search: assert property (p_search)
      else $error("speed search pulse wrong");
   property p_stop_req; ramp_stop_req == $past(jog_conflict_alarm); endproperty
   a_stop_req: assert property (p_stop_req)
      else $error("ramp stop does not follow jog alarm");
   // Jog must have run well before the conflict alarm can rise
   property p_jog_time; $rose(jog_conflict_alarm) |-> $past(jog_run, 8);
   endproperty
   a_jog_time: assert property (p_jog_time)
      else $error("jog alarm too early");
   property p_jog_freq;
      jog_run && $past(jog_run) && !jog_conflict_alarm
         |-> freq_command == jog_frequency_param;
   endproperty
   a_jog_freq: assert property (p_jog_freq)
      else $error("jog frequency not used");
   property p_jog_ramp; jog_run |-> jog_ramp_sel; endproperty
   a_jog_ramp: assert property (p_jog_ramp)
      else $error("jog ramp not selected");
   // Disable input is seen one edge before the registered direction
   property p_rev;
      run_reverse |-> jog_run && !$past(reverse_disable);
   endproperty
   a_rev: assert property (p_rev)
      else $error("reverse jog while disabled");
   property p_ef_term;
      external_fault_indication |-> ext_fault_terminal inside {[1:6]} ##1
         (!external_fault_indication || $stable(ext_fault_terminal));
   endproperty
   a_ef_term: assert property (p_ef_term)
      else $error("fault terminal number bad");
   property p_rst_run;
      drive_running && external_fault_indication |=> external_fault_indication;
   endproperty
   a_rst_run: assert property (p_rst_run)
      else $error("fault cleared during run");
   property p_fast;
      fast_stop_active && !motor_stopped |=> fast_stop_active;
   endproperty
   a_fast: assert property (p_fast)
      else $error("fast stop left before standstill");

   // Main scenarios reached
   c_search: cover property (speed_search_start);
   c_jogcf: cover property ($rose(jog_conflict_alarm));
   c_fault: cover property ($rose(external_fault_indication));
endmodule

bind dit_top dit_sva #(.DEB_CYC(DEB_CYC), .JOGCF_CYC(JOGCF_CYC),
   .UDSTEP_CYC(UDSTEP_CYC)) i_dit_sva (.clk_sys(clk_sys), .rstn(rstn),
   .motor_stopped(motor_stopped), .reverse_disable(reverse_disable),
   .drive_running(drive_running),
   .jog_frequency_param(jog_frequency_param), .freq_command(freq_command),
   .run_reverse(run_reverse), .jog_run(jog_run), .jog_ramp_sel(jog_ramp_sel),
   .output_disable(output_disable), .output_block_alarm(output_block_alarm),
   .speed_search_start(speed_search_start),
   .fast_stop_active(fast_stop_active), .ramp_stop_req(ramp_stop_req),
   .jog_conflict_alarm(jog_conflict_alarm),
   .external_fault_indication(external_fault_indication),
   .ext_fault_terminal(ext_fault_terminal));

// [tb/dit_contacts.sv]
// Model of six external contacts that bounce on every change.
// Assumes bounce shorter than the debounce filter of the block.
`timescale 1ns/10ps

module dit_contacts (
   input  wire       clk_sys,
   input  wire [5:0] want,
   output reg  [5:0] term_in
);
   reg [5:0] last; // Last settled request
   reg [5:0] chg;  // Contacts now bouncing
   reg [1:0] bnc;  // Bounce cycles left
   initial begin
      term_in = 6'h00;
      last    = 6'h00;
      chg     = 6'h00;
      bnc     = 2'h0;
   end
   // Changed contacts chatter for three cycles, then settle
   always @(posedge clk_sys) begin
      if (want != last) begin
         chg  <= want ^ last;
         last <= want;
         bnc  <= 2'h3;
      end else if (bnc != 2'h0) begin
         term_in <= term_in ^ chg; // Single-cycle runs only
         bnc     <= bnc - 2'h1;
      end else begin
         term_in <= last;
      end
   end
endmodule

// [tb/dit_top_tb.sv]
// Self-checking bench for the input terminal function block.
// Assumes dit_contacts as the far side and small timing parameters.
`timescale 1ns/10ps
`include "dit_defs.vh"

module dit_top_tb;
   reg clk_sys = 1'b0, rstn = 1'b0, run_cmd = 1'b0, drv_run = 1'b0;
   reg mstop = 1'b0, hold_en = 1'b1, rev_dis = 1'b0;
   reg [5:0]  want = 6'h00;   // Requested contact states
   reg [41:0] fsel = 42'h0;   // Terminal codes
   reg [15:0] upper = 16'h0003, lower = 16'h0002, ain = 16'h0001;
   reg [2:0]  src1 = 3'h2, src2 = 3'h0;
   reg [15:0] fref = 16'h0002, jogf = 16'h0002;
   reg s2act = 1'b0;          // Second source selected
   wire jrs, rsr;
   wire [5:0] term;
   wire [15:0] fcmd;
   wire [1:0] rsel;
   wire rrev, jrun, odis, ss, fst, jcf, ise, efi, oh2, rhold;
   wire [2:0] eft;
   wire [1:0] efm;
   integer n_errors = 0, check_count = 0, cyc = 0, i, k;

   dit_contacts i_dit_contacts (.clk_sys(clk_sys), .want(want),
      .term_in(term));
   dit_top #(.DEB_CYC(4), .JOGCF_CYC(50), .UDSTEP_CYC(8)) i_dit_top (
      .clk_sys(clk_sys), .rstn(rstn), .term_in(term),
      .input_function_select(fsel), .run_cmd(run_cmd),
      .drive_running(drv_run), .motor_stopped(mstop),
      .freq_ref_in(fref), .jog_frequency_param(jogf),
      .freq_upper_limit(upper), .freq_lower_limit(lower), .analog_in(ain),
      .analog_function(2'h2), .freq_source_select_1(src1),
      .freq_source_select_2(src2), .source_2_active(s2act),
      .freq_command_hold_enable(hold_en), .reverse_disable(rev_dis),
      .freq_command(fcmd), .run_reverse(rrev), .jog_run(jrun),
      .jog_ramp_sel(jrs), .ramp_pair_sel(rsel), .ramp_hold(rhold),
      .output_disable(odis), .output_block_alarm(),
      .speed_search_start(ss), .fast_stop_active(fst), .ramp_stop_req(rsr),
      .jog_conflict_alarm(jcf), .input_selection_error(ise),
      .external_fault_indication(efi), .ext_fault_terminal(eft),
      .ext_fault_stop_mode(efm), .ext_fault_alarm(),
      .external_overheat_alarm(oh2));

   // 25 ns clock
   initial forever #12.5 clk_sys = ~clk_sys;

   task wt(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Set a terminal code
   task code(input integer t, input [6:0] c);
      fsel[7*t +: 7] = c;
      wt(4);
   endtask
   // Move a contact, then wait past bounce and debounce
   task sw(input integer t, input v);
      want[t] = v;
      wt(16);
   endtask
   task chk(input [15:0] seen, input [15:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
            exp);
      end
   endtask
   task finish_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard, far above the sequence length
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         n_errors = n_errors + 1;
         finish_test;
      end
   end

   initial begin
      fsel = {`DIT_F_OH2, `DIT_F_FRST, `DIT_F_EF_LO, `DIT_F_BB_NO,
              `DIT_F_DOWN, `DIT_F_UP};
      wt(2);
      rstn = 1'b1;
      wt(2);
      chk(ise, 1'b0);
      code(1, 7'h00);
      chk(ise, 1'b1);
      code(1, `DIT_F_DOWN);
      run_cmd = 1'b1;
      // Up to the upper clamp, both held, down to min(analog, lower)
      sw(0, 1'b1);
      wt(40);
      chk(fcmd, 16'h0003);
      sw(1, 1'b1);
      wt(30);
      chk(fcmd, 16'h0003);
      sw(0, 1'b0);
      wt(40);
      chk(fcmd, 16'h0001);
      sw(1, 1'b0);
      run_cmd = 1'b0;
      wt(4);
      chk(fcmd, 16'h0001);
      sw(0, 1'b1);
      chk(fcmd, 16'h0000);
      sw(0, 1'b0);
      hold_en = 1'b0;
      run_cmd = 1'b1;
      sw(0, 1'b1);
      sw(0, 1'b0);
      // Two steps from the lower clamp reach the upper limit
      chk(fcmd, 16'h0003);
      run_cmd = 1'b0;
      wt(4);
      chk(fcmd, 16'h0000);
      src1 = 3'h0;
      run_cmd = 1'b1;
      sw(0, 1'b1);
      chk(fcmd, 16'h0002);
      sw(0, 1'b0);
      // Second source selects up/down: clamped stored value shows
      src2 = 3'h2;
      s2act = 1'b1;
      wt(4);
      chk(fcmd, 16'h0001);
      s2act = 1'b0;
      // Block, then release under run: one search pulse
      sw(2, 1'b1);
      chk(odis, 1'b1);
      want[2] = 1'b0;
      k = 0;
      for (i = 0; i < 20; i = i + 1) begin
         wt(1);
         k = k + ss;
      end
      chk(k, 1);
      chk(odis, 1'b0);
      // External fault on S4, reset refused in run
      run_cmd = 1'b0;
      sw(3, 1'b1);
      chk({efi, eft, efm}, {1'b1, 3'h4, `DIT_EF_RAMP});
      sw(3, 1'b0);
      drv_run = 1'b1;
      sw(4, 1'b1);
      sw(4, 1'b0);
      chk(efi, 1'b1);
      drv_run = 1'b0;
      sw(4, 1'b1);
      chk(efi, 1'b0);
      sw(4, 1'b0);
      sw(5, 1'b1);
      chk(oh2, 1'b1);
      // Ramp pair select and ramp hold
      code(2, `DIT_F_ACC1);
      code(3, `DIT_F_ACC2);
      code(5, `DIT_F_HOLD);
      chk(rhold, 1'b1);
      sw(2, 1'b1);
      chk(rsel, 2'h1);
      sw(3, 1'b1);
      chk(rsel, 2'h3);
      sw(2, 1'b0);
      chk(rsel, 2'h2);
      sw(3, 1'b0);
      sw(5, 1'b0);
      // Fast stop stays until standstill and release
      code(4, `DIT_F_FST_NO);
      run_cmd = 1'b1;
      drv_run = 1'b1;
      sw(4, 1'b1);
      chk(fst, 1'b1);
      sw(4, 1'b0);
      run_cmd = 1'b0;
      drv_run = 1'b0;
      wt(4);
      chk(fst, 1'b1);
      mstop = 1'b1;
      wt(4);
      chk(fst, 1'b0);
      // Jogs: forward, reverse, disabled reverse, conflict
      code(0, `DIT_F_FORWARD_JOG);
      code(1, `DIT_F_REVERSE_JOG);
      sw(0, 1'b1);
      chk({jrun, rrev}, 2'h2);
      chk(fcmd, 16'h0002);
      chk(jrs, 1'b1);
      sw(0, 1'b0);
      sw(1, 1'b1);
      chk({jrun, rrev}, 2'h3);
      rev_dis = 1'b1;
      wt(4);
      chk(jrun, 1'b0);
      want[0] = 1'b1;
      wt(40);
      chk(jcf, 1'b0);
      wt(30);
      chk(jcf, 1'b1);
      chk(rsr, 1'b1);
      finish_test;
   end
endmodule
